/* adc_seq_chk.sv */
// assertions on the conversion and command register group
`timescale 1ns/1ps
module adc_seq_chk #(parameter int CHANNELS = 4) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire conv_cmd_pkg::reg_req_t req,
  input wire logic pass_done,
  input wire logic [CHANNELS-1:0] clear_enabled,
  input wire logic [CHANNELS-1:0] slew_enabled,
  input wire logic converter_busy,
  input wire logic converter_power_on,
  input wire logic pass_start,
  input wire logic continuous_run,
  input wire logic [CHANNELS-1:0] source_mask,
  input wire logic dac_load_pulse,
  input wire logic [CHANNELS-1:0] dac_clear_pulse,
  input wire logic [CHANNELS-1:0] dac_clear_slew,
  input wire logic digital_reset,
  input wire logic reset_seen_flag,
  input wire logic alert_n
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!resetn);
  logic key_wr;
  logic seq_wr;
  assign key_wr = req.wr && clock_enable && req.addr == 8'h44;
  assign seq_wr = req.wr && clock_enable && req.addr == 8'h42;
  sequence s_key1; key_wr && req.wdata == 16'h15fa; endsequence
  sequence s_key2; key_wr && req.wdata == 16'haf51; endsequence
  a_load_key: assert property (key_wr && req.wdata == 16'h953a |=> dac_load_pulse)
    else $error("load key gave no pulse");
  a_clear_key: assert property (key_wr && req.wdata == 16'h73d1 |=>
    dac_clear_pulse == $past(clear_enabled) && dac_clear_slew == $past(clear_enabled & slew_enabled))
    else $error("clear key channels wrong");
  a_soft_reset: assert property (s_key1 ##1 s_key2 |-> ##2 digital_reset)
    else $error("key pair gave no reset");
  a_reset_shown: assert property (digital_reset |=> reset_seen_flag && !alert_n)
    else $error("reset not shown");
  a_power_down: assert property (seq_wr && req.wdata[1:0] == 2'h3 |->
    ##[1:2] !converter_power_on && !continuous_run) else $error("no power down");
  a_powerup_busy: assert property ($rose(converter_power_on) |-> converter_busy)
    else $error("not busy at power up");
  a_single_go: assert property (seq_wr && req.wdata[1:0] == 2'h1 && converter_power_on &&
    !converter_busy |=> pass_start ##1 converter_busy) else $error("single pass not started");
  a_cont_again: assert property (continuous_run && pass_done |-> ##[1:2] pass_start)
    else $error("continuous pass not restarted");
  a_cont_mask: assert property (continuous_run |-> source_mask == '1)
    else $error("mask not channels a-d");
endmodule : adc_seq_chk
bind adc_sequence_and_command_regs adc_seq_chk #(.CHANNELS(CHANNELS)) u_chk (.*);

/* adc_sequence_and_command_regs.sv */
// conversion sequencing, overheat reset, key command, spare and revision registers
`timescale 1ns/1ps
`include "conv_cmd_defs.svh"
module adc_sequence_and_command_regs #(
  parameter int POWERUP_CYCLES = `POWERUP_CYCLES,
  parameter logic [7:0] REVISION_CODE = 8'h5a, // arbitrary value
  parameter int CHANNELS = 4
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic clock_enable,
  input wire conv_cmd_pkg::reg_req_t req,
  output logic [15:0] rdata,
  output logic rvalid,
  input wire logic overheat,
  input wire logic pass_done,
  input wire logic [CHANNELS-1:0] clear_enabled,
  input wire logic [CHANNELS-1:0] slew_enabled,
  input wire logic reset_seen_clear,
  output logic converter_busy,
  output logic converter_power_on,
  output logic pass_start,
  output logic continuous_run,
  output logic [CHANNELS-1:0] source_mask,
  output logic enables_frozen,
  output logic dac_load_pulse,
  output logic [CHANNELS-1:0] dac_clear_pulse,
  output logic [CHANNELS-1:0] dac_clear_slew,
  output logic digital_reset,
  output logic reset_seen_flag,
  output logic alert_n
);
  // ----------------------------------------
  // decode
  // ----------------------------------------
  function automatic logic hit(input conv_cmd_pkg::reg_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  // a pass of a continuous sequence is under way
  function automatic logic runs_continuous(input conv_cmd_pkg::conv_state_t st,
                                           input conv_cmd_pkg::seq_code_t sq);
    runs_continuous = st == conv_cmd_pkg::conv_pass && sq == conv_cmd_pkg::seq_continuous;
  endfunction : runs_continuous

  // overheat only resets the device while the enable bit is set
  function automatic logic thermal_trip(input logic hot, input logic enable);
    thermal_trip = hot && enable;
  endfunction : thermal_trip

  conv_cmd_pkg::seq_code_t seq_reg;
  logic overheat_reset_enable_reg;
  logic [15:0] spare_reg;
  logic key1_pending_reg;
  conv_cmd_pkg::conv_state_t state_reg;
  logic [$clog2(POWERUP_CYCLES+1)-1:0] pu_count_reg;
  logic soft_reset_reg;
  logic [1:0] seq_w;
  logic seq_write;
  logic cmd_write;

  assign seq_w = req.wdata[`SEQ_MSB:0];
  assign seq_write = hit(req, `ADDR_FAST_CONV);
  assign cmd_write = hit(req, `ADDR_CMD_KEY);

  // ----------------------------------------
  // writable registers
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      seq_reg <= conv_cmd_pkg::seq_idle;
      overheat_reset_enable_reg <= 1'b0;
      spare_reg <= `RESET_WORD;
    end else if (digital_reset) begin
      seq_reg <= conv_cmd_pkg::seq_idle;
      overheat_reset_enable_reg <= 1'b0;
      spare_reg <= `RESET_WORD;
    end else if (clock_enable) begin
      if (seq_write) begin
        seq_reg <= conv_cmd_pkg::seq_code_t'(seq_w);
      end
      if (hit(req, `ADDR_OVERHEAT)) begin
        overheat_reset_enable_reg <= req.wdata[0];
      end
      if (hit(req, `ADDR_SPARE)) begin
        spare_reg <= req.wdata;
      end
    end
  end

  // ----------------------------------------
  // converter power and sequencing
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= conv_cmd_pkg::conv_off;
      pu_count_reg <= '0;
      pass_start <= 1'b0;
    end else if (digital_reset) begin
      state_reg <= conv_cmd_pkg::conv_off;
      pu_count_reg <= '0;
      pass_start <= 1'b0;
    end else if (clock_enable) begin
      pass_start <= 1'b0;
      if (seq_write && seq_w == 2'(conv_cmd_pkg::seq_power_down)) begin
        state_reg <= conv_cmd_pkg::conv_off;
      end else if (seq_write && state_reg == conv_cmd_pkg::conv_off) begin
        state_reg <= conv_cmd_pkg::conv_powering;
        pu_count_reg <= '0;
      end else if (seq_write && seq_w == 2'(conv_cmd_pkg::seq_idle)) begin
        if (state_reg == conv_cmd_pkg::conv_pass) begin
          state_reg <= conv_cmd_pkg::conv_ready;
        end
      end else if (seq_write && state_reg != conv_cmd_pkg::conv_powering) begin
        state_reg <= conv_cmd_pkg::conv_pass;
        pass_start <= 1'b1;
      end else begin
        unique case (state_reg)
          conv_cmd_pkg::conv_off: begin
          end
          conv_cmd_pkg::conv_powering: begin
            if (pu_count_reg == ($bits(pu_count_reg))'(POWERUP_CYCLES - 1)) begin
              state_reg <= conv_cmd_pkg::conv_ready;
            end else begin
              pu_count_reg <= pu_count_reg + 1'b1;
            end
          end
          conv_cmd_pkg::conv_ready: begin
          end
          conv_cmd_pkg::conv_pass: begin
            if (pass_done) begin
              if (seq_reg == conv_cmd_pkg::seq_continuous) begin
                pass_start <= 1'b1;
              end else begin
                state_reg <= conv_cmd_pkg::conv_ready;
              end
            end
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // converter status
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      converter_busy <= 1'b0;
      converter_power_on <= 1'b0;
    end else if (clock_enable) begin
      converter_busy <= state_reg == conv_cmd_pkg::conv_powering ||
                        state_reg == conv_cmd_pkg::conv_pass;
      converter_power_on <= state_reg != conv_cmd_pkg::conv_off;
    end
  end

  // enables stay frozen while a continuous sequence runs
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      continuous_run <= 1'b0;
      enables_frozen <= 1'b0;
    end else if (clock_enable) begin
      continuous_run <= runs_continuous(state_reg, seq_reg);
      enables_frozen <= runs_continuous(state_reg, seq_reg);
    end
  end

  // only the four channel inputs are converted in this mode
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      source_mask <= '0;
    end else if (clock_enable) begin
      source_mask <= '1;
    end
  end

  // ----------------------------------------
  // command keys
  // ----------------------------------------
  // first reset key is kept only until the very next write
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      key1_pending_reg <= 1'b0;
    end else if (clock_enable) begin
      if (digital_reset) begin
        key1_pending_reg <= 1'b0;
      end else if (req.wr) begin
        key1_pending_reg <= cmd_write && req.wdata == `KEY_RESET1;
      end
    end
  end

  // second key right after the first one
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      soft_reset_reg <= 1'b0;
    end else if (clock_enable) begin
      soft_reset_reg <= !digital_reset && cmd_write && key1_pending_reg &&
                        req.wdata == `KEY_RESET2;
    end
  end

  // load and clear strobes towards the converters
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      dac_load_pulse <= 1'b0;
      dac_clear_pulse <= '0;
      dac_clear_slew <= '0;
    end else if (clock_enable) begin
      dac_load_pulse <= 1'b0;
      dac_clear_pulse <= '0;
      if (!digital_reset && cmd_write) begin
        unique case (req.wdata)
          `KEY_DAC_LOAD: dac_load_pulse <= 1'b1;
          `KEY_DAC_CLEAR: begin
            dac_clear_pulse <= clear_enabled;
            dac_clear_slew <= clear_enabled & slew_enabled;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // overheat reset and reset indication
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      digital_reset <= 1'b0;
    end else if (clock_enable) begin
      digital_reset <= thermal_trip(overheat, overheat_reset_enable_reg) ||
                       soft_reset_reg;
    end
  end

  // a set wins over a clear in the same cycle
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      reset_seen_flag <= 1'b1;
    end else if (clock_enable) begin
      if (digital_reset) begin
        reset_seen_flag <= 1'b1;
      end else if (reset_seen_clear) begin
        reset_seen_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      alert_n <= 1'b0;
    end else if (clock_enable) begin
      alert_n <= !(digital_reset || (reset_seen_flag && !reset_seen_clear));
    end
  end

  // ----------------------------------------
  // readback
  // ----------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid <= 1'b0;
    end else if (clock_enable) begin
      rvalid <= req.rd;
    end
  end

  // data stands for one cycle only, zero otherwise
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= `RESET_WORD;
    end else if (clock_enable) begin
      rdata <= `RESET_WORD;
      if (req.rd) begin
        unique case (req.addr)
          `ADDR_FAST_CONV: rdata <= {14'h0000, seq_reg};
          `ADDR_OVERHEAT: rdata <= {15'h0000, overheat_reset_enable_reg};
          `ADDR_SPARE: rdata <= spare_reg;
          `ADDR_REVISION: rdata <= {8'h00, REVISION_CODE[`REV_MSB:0]};
          default: rdata <= `RESET_WORD;
        endcase
      end
    end
  end
endmodule : adc_sequence_and_command_regs

/* adc_sequence_and_command_regs_bench.sv */
// self-checking bench for the conversion and command register group
`timescale 1ns/1ps
module adc_sequence_and_command_regs_bench;
  localparam logic [7:0] REV = 8'h3c; // arbitrary value
  logic clock = 0, resetn = 0, clock_enable = 1, overheat = 0, reset_seen_clear = 0;
  conv_cmd_pkg::reg_req_t req = '0;
  logic [3:0] clear_enabled = 4'h5, slew_enabled = 4'h3, lat = 4'h1;
  logic [15:0] rdata;
  logic rvalid, pass_done, converter_busy, converter_power_on, pass_start, continuous_run;
  logic enables_frozen, dac_load_pulse, digital_reset, reset_seen_flag, alert_n;
  logic [3:0] source_mask, dac_clear_pulse, dac_clear_slew;
  int error_cnt = 0, compares = 0, starts = 0, resets = 0, s;
  adc_sequence_and_command_regs #(.POWERUP_CYCLES(20), .REVISION_CODE(REV)) DUT (.*);
  conv_model u_conv (.clock(clock), .resetn(resetn), .lat(lat), .pass_start(pass_start),
    .pass_done(pass_done));
  always #5 clock = ~clock;
  always @(negedge clock) begin
    starts += pass_start;
    resets += digital_reset;
  end
  task finish_test;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task step;
    @(posedge clock);
    #1;
  endtask : step
  task put(input conv_cmd_pkg::reg_req_t r);
    req = r;
    step;
  endtask : put
  task wr(input logic [7:0] a, input logic [15:0] d);
    put({2'b10, a, d});
    put('0);
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] exp);
    put({2'b01, a, 16'h0000});
    chk({15'h0, rvalid}, 16'h1);
    chk(rdata, exp);
    put('0);
  endtask : rd
  task key(input logic [15:0] d, input logic [15:0] exp);
    put({2'b10, 8'h44, d});
    chk({dac_load_pulse, dac_clear_pulse, dac_clear_slew}, exp);
    put('0);
  endtask : key
  task wait_ready;
    int n;
    n = 0;
    step;
    while (converter_busy !== 1'b0 && n < 200) begin
      step;
      n++;
    end
    chk({15'h0, converter_busy}, 16'h0);
  endtask : wait_ready
  initial begin
    repeat (4) @(posedge clock);
    #1 resetn = 1;
    chk({reset_seen_flag, alert_n}, 16'h2);
    for (int a = 0; a < 6; a++) rd(8'h42 + 8'(a), a == 4 ? {8'h00, REV} : 16'h0);
    reset_seen_clear = 1;
    step;
    reset_seen_clear = 0;
    step;
    chk({reset_seen_flag, alert_n}, 16'h1);
    clock_enable = 0;
    wr(8'h45, 16'h1234);
    clock_enable = 1;
    rd(8'h45, 16'h0);
    wr(8'h45, 16'hffff);
    rd(8'h45, 16'hffff);
    wr(8'h43, 16'hfffe);
    rd(8'h43, 16'h0);
    wr(8'h42, 16'hfffc);
    wait_ready;
    rd(8'h42, 16'h0);
    wr(8'h42, 16'h1);
    wait_ready;
    rd(8'h42, 16'h1);
    wr(8'h42, 16'h1);
    wait_ready;
    chk(16'(starts), 16'h2);
    lat = 4'h8;
    wr(8'h42, 16'h2);
    repeat (40) step;
    chk({continuous_run, enables_frozen, source_mask, 1'(starts > 4)}, 16'h7f);
    while (pass_start !== 1'b1) step;
    wr(8'h42, 16'h0);
    wait_ready;
    chk({15'h0, continuous_run}, 16'h0);
    lat = 4'h1;
    wr(8'h42, 16'h3);
    step;
    chk({15'h0, converter_power_on}, 16'h0);
    wr(8'h42, 16'h1);
    wait_ready;
    s = starts;
    wr(8'h42, 16'h1);
    wait_ready;
    chk(16'(starts - s), 16'h1);
    key(16'h0000, 16'h0);
    key(16'h953a, 16'h100);
    key(16'h73d1, 16'h051);
    s = resets;
    wr(8'h44, 16'h15fa);
    wr(8'h44, 16'h1234);
    wr(8'h44, 16'haf51);
    wr(8'h44, 16'h15fa);
    wr(8'h45, 16'h00aa);
    wr(8'h44, 16'haf51);
    repeat (3) step;
    chk(16'(resets - s), 16'h0);
    put({2'b10, 8'h44, 16'h15fa});
    wr(8'h44, 16'haf51);
    repeat (3) step;
    chk({15'h0, resets > s}, 16'h1);
    chk({reset_seen_flag, alert_n}, 16'h2);
    rd(8'h45, 16'h0);
    s = resets;
    overheat = 1;
    repeat (2) step;
    overheat = 0;
    chk(16'(resets - s), 16'h0);
    wr(8'h43, 16'h1);
    overheat = 1;
    step;
    overheat = 0;
    repeat (2) step;
    chk({15'h0, resets > s}, 16'h1);
    rd(8'h43, 16'h0);
    finish_test;
  end
  initial begin
    #100000;
    error_cnt++;
    finish_test;
  end
endmodule : adc_sequence_and_command_regs_bench

/* conv_cmd_defs.svh */
// register offsets, field positions, keys and timing counts for the conversion and command group
`ifndef CONV_CMD_DEFS_SVH
`define CONV_CMD_DEFS_SVH
`define ADDR_FAST_CONV 8'h42
`define ADDR_OVERHEAT 8'h43
`define ADDR_CMD_KEY 8'h44
`define ADDR_SPARE 8'h45
`define ADDR_REVISION 8'h46
`define RESET_WORD 16'h0000
`define SEQ_MSB 1
`define REV_MSB 7
`define KEY_NOP 16'h0000
`define KEY_RESET1 16'h15fa
`define KEY_RESET2 16'haf51
`define KEY_DAC_LOAD 16'h953a
`define KEY_DAC_CLEAR 16'h73d1
`define POWERUP_TIME_US 100
`define CLOCK_MHZ 100
`define POWERUP_CYCLES (`POWERUP_TIME_US * `CLOCK_MHZ)
`endif

/* conv_cmd_pkg.sv */
// types shared by the conversion and command register group
package conv_cmd_pkg;
  typedef enum logic [1:0] {
    seq_idle = 2'h0,
    seq_single = 2'h1,
    seq_continuous = 2'h2,
    seq_power_down = 2'h3
  } seq_code_t;
  typedef enum {conv_off, conv_powering, conv_ready, conv_pass} conv_state_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [15:0] wdata;
  } reg_req_t;
endpackage : conv_cmd_pkg

/* conv_model.sv */
// converter model answering each pass start with a pass end
`timescale 1ns/1ps
module conv_model (
  input wire logic clock,
  input wire logic resetn,
  input wire logic [3:0] lat,
  input wire logic pass_start,
  output logic pass_done
);
  logic [3:0] cnt_reg;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 4'h0;
      pass_done <= 1'b0;
    end else begin
      pass_done <= (cnt_reg == 4'h1);
      if (pass_start) cnt_reg <= lat;
      else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg - 4'h1;
    end
  end
endmodule : conv_model
